// ===== hw/gpx_pkg.sv
// package: register map, field positions and timing for the pin port
`default_nettype none
package gpx_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 32;
  localparam int PIN_W = 8;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_PIN_DIRECTION = 17'h07F18;
  localparam logic [ADDR_W-1:0] IDX_PIN_OUTPUT_LATCH = 17'h07F19;
  localparam logic [ADDR_W-1:0] IDX_PIN_INPUT_SAMPLE = 17'h07F1A;
  localparam logic [ADDR_W-1:0] IDX_UTILITY_PIN_MUX_CONFIG = 17'h07F1B;
  localparam int BYTE_PER_WORD = 4;
  // reset values
  localparam logic [PIN_W-1:0] RST_PIN_DIRECTION = 8'h00;
  localparam logic [PIN_W-1:0] RST_PIN_OUTPUT_LATCH = 8'h00;
  localparam logic [PIN_W-1:0] RST_PIN_INPUT_SAMPLE = 8'h00;
  localparam logic [4:0] RST_UTILITY_PIN_MUX_CONFIG = 5'h00;
  // utility config fields
  localparam int CFG_W = 5;
  localparam int SERIAL_RX_SOURCE_SELECT = 0;
  localparam int PIN1_SERIAL_TX_SELECT = 1;
  localparam int TIMER0_TRIGGER_SELECT = 2;
  localparam int TIMER1_TRIGGER_SELECT = 3;
  localparam int PIN4_FRAME_PULSE_SELECT = 4;
  // pins with alternate functions
  localparam int PIN_RX = 0;
  localparam int PIN_TX = 1;
  localparam int PIN_T0 = 2;
  localparam int PIN_T1 = 3;
  localparam int PIN_FRAME = 4;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing: frame strobe seen by a timer stays active at least this long
  localparam int CLK_PERIOD_PS = 5000;
  localparam int FRAME_STB_MIN_NS = 1000;
  localparam int FRAME_STB_CYC = (FRAME_STB_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STB_CNT_W = 8;
  typedef enum logic [2:0] {
    GPX_SEL_NONE,
    GPX_SEL_DIR,
    GPX_SEL_OUT,
    GPX_SEL_IN,
    GPX_SEL_CFG
  } gpx_sel_t;
endpackage : gpx_pkg
`default_nettype wire

// ===== hw/gpx_frame_stretch.sv
// module: stretches the frame write strobe to the least timer-visible width
`timescale 1ns/10ps
`default_nettype none
module gpx_frame_stretch (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // strobe in, stretched level out
  input wire logic stb,
  output logic active
);
  logic [gpx_pkg::STB_CNT_W-1:0] cnt_r;
  logic [gpx_pkg::STB_CNT_W-1:0] cnt_nxt;
  logic active_r;
  logic active_nxt;
  logic [gpx_pkg::STB_CNT_W-1:0] run_r;

  // ==========================================================
  // counter
  always_comb
  begin
    // retrigger reloads, so back-to-back frames never shorten the level
    if (stb)
      cnt_nxt = gpx_pkg::STB_CNT_W'(gpx_pkg::FRAME_STB_CYC);
    else if (cnt_r != '0)
      cnt_nxt = cnt_r - 8'h01;
    else
      cnt_nxt = cnt_r;
    active_nxt = (cnt_nxt != '0);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_r <= '0;
      active_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      active_r <= active_nxt;
    end
  end

  assign active = active_r;

  // ==========================================================
  // checks
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      run_r <= '0;
    else if (!active_r)
      run_r <= '0;
    else if (run_r != 8'hFF)
      run_r <= run_r + 8'h01;
  end

  chk_stretch_width: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(active_r) |-> run_r >= 8'(gpx_pkg::FRAME_STB_CYC))
    else $error("frame strobe level shorter than minimum");
endmodule : gpx_frame_stretch
`default_nettype wire

// ===== hw/gpx_port.sv
// module: eight-pin port with alternate-function muxing, AXI4-Lite registers
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module gpx_port (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address, data and response
  input wire logic [gpx_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [gpx_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [gpx_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [gpx_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // port pins
  input wire logic [gpx_pkg::PIN_W-1:0] pin_in,
  output logic [gpx_pkg::PIN_W-1:0] pin_out,
  output logic [gpx_pkg::PIN_W-1:0] pin_oe,
  // microcontroller and frame side
  input wire logic mcu_port3_bit1,
  input wire logic frame_pulse,
  input wire logic frame_wr_stb,
  output logic mcu_port3_bit0,
  output logic mcu_port3_bit4,
  output logic mcu_port3_bit5
);
  // ==========================================================
  // decode
  function automatic gpx_pkg::gpx_sel_t reg_sel(input logic [gpx_pkg::ADDR_W-1:0] a);
    gpx_pkg::gpx_sel_t s;
    s = gpx_pkg::GPX_SEL_NONE;
    if (a == gpx_pkg::ADDR_W'(gpx_pkg::IDX_PIN_DIRECTION * gpx_pkg::BYTE_PER_WORD))
      s = gpx_pkg::GPX_SEL_DIR;
    else if (a == gpx_pkg::ADDR_W'(gpx_pkg::IDX_PIN_OUTPUT_LATCH * gpx_pkg::BYTE_PER_WORD))
      s = gpx_pkg::GPX_SEL_OUT;
    else if (a == gpx_pkg::ADDR_W'(gpx_pkg::IDX_PIN_INPUT_SAMPLE * gpx_pkg::BYTE_PER_WORD))
      s = gpx_pkg::GPX_SEL_IN;
    else if (a == gpx_pkg::ADDR_W'(gpx_pkg::IDX_UTILITY_PIN_MUX_CONFIG * gpx_pkg::BYTE_PER_WORD))
      s = gpx_pkg::GPX_SEL_CFG;
    return s;
  endfunction : reg_sel

  // ==========================================================
  // state
  logic [gpx_pkg::PIN_W-1:0] pin_direction_r, pin_direction_nxt;
  logic [gpx_pkg::PIN_W-1:0] pin_output_latch_r, pin_output_latch_nxt;
  logic [gpx_pkg::PIN_W-1:0] pin_input_sample_r;
  logic [gpx_pkg::CFG_W-1:0] cfg_r, cfg_nxt;
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [gpx_pkg::ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [7:0] wbyte_r, wbyte_nxt;
  logic wlane_r, wlane_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [gpx_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [gpx_pkg::PIN_W-1:0] pin_out_r, pin_out_nxt, pin_oe_r;
  logic rx_r, rx_nxt, t0_r, t0_nxt, t1_r, t1_nxt;
  logic frame_stb_active;
  logic do_wr;
  gpx_pkg::gpx_sel_t wsel, rsel;

  gpx_frame_stretch u_stretch (
    .aclk(aclk),
    .aresetn(aresetn),
    .stb(frame_wr_stb),
    .active(frame_stb_active)
  );

  // ==========================================================
  // AXI4-Lite slave and register writes
  always_comb
  begin
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    awaddr_nxt = awaddr_r;
    wbyte_nxt = wbyte_r;
    wlane_nxt = wlane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    pin_direction_nxt = pin_direction_r;
    pin_output_latch_nxt = pin_output_latch_r;
    cfg_nxt = cfg_r;
    wsel = reg_sel(awaddr_r);
    do_wr = aw_held_r && w_held_r && !bvalid_r;
    if (awvalid && awready_r)
    begin
      aw_held_nxt = 1'b1;
      awaddr_nxt = awaddr;
    end
    if (wvalid && wready_r)
    begin
      w_held_nxt = 1'b1;
      wbyte_nxt = wdata[7:0];
      wlane_nxt = wstrb[0];
    end
    if (bvalid_r && bready)
      bvalid_nxt = 1'b0;
    if (do_wr)
    begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = (wsel == gpx_pkg::GPX_SEL_NONE) ? gpx_pkg::RESP_SLVERR : gpx_pkg::RESP_OKAY;
      // only the low byte lane carries register bits
      if (wlane_r)
      begin
        unique case (wsel)
          gpx_pkg::GPX_SEL_DIR: pin_direction_nxt = wbyte_r;
          gpx_pkg::GPX_SEL_OUT: pin_output_latch_nxt = wbyte_r;
          gpx_pkg::GPX_SEL_CFG: cfg_nxt = wbyte_r[gpx_pkg::CFG_W-1:0];
          gpx_pkg::GPX_SEL_IN,
          gpx_pkg::GPX_SEL_NONE: ;
        endcase
      end
    end
    awready_nxt = !aw_held_nxt && !bvalid_nxt;
    wready_nxt = !w_held_nxt && !bvalid_nxt;
  end

  // ==========================================================
  // register reads
  always_comb
  begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    rsel = reg_sel(araddr);
    if (rvalid_r && rready)
      rvalid_nxt = 1'b0;
    if (arvalid && arready_r)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = gpx_pkg::RESP_OKAY;
      rdata_nxt = '0;
      unique case (rsel)
        gpx_pkg::GPX_SEL_DIR: rdata_nxt[7:0] = pin_direction_r;
        gpx_pkg::GPX_SEL_OUT: rdata_nxt[7:0] = pin_output_latch_r;
        gpx_pkg::GPX_SEL_IN: rdata_nxt[7:0] = pin_input_sample_r;
        // reserved bits 7:5 read zero
        gpx_pkg::GPX_SEL_CFG: rdata_nxt[gpx_pkg::CFG_W-1:0] = cfg_r;
        gpx_pkg::GPX_SEL_NONE: rresp_nxt = gpx_pkg::RESP_SLVERR;
      endcase
    end
    arready_nxt = !rvalid_nxt;
  end

  // ==========================================================
  // pin and alternate-function muxing
  always_comb
  begin
    pin_out_nxt = pin_output_latch_r;
    if (cfg_r[gpx_pkg::PIN4_FRAME_PULSE_SELECT])
      pin_out_nxt[gpx_pkg::PIN_FRAME] = frame_pulse;
    if (cfg_r[gpx_pkg::PIN1_SERIAL_TX_SELECT])
      pin_out_nxt[gpx_pkg::PIN_TX] = mcu_port3_bit1;
    // pin sample comes from the pad, so an output pin loops back and can trigger a timer
    t1_nxt = cfg_r[gpx_pkg::TIMER1_TRIGGER_SELECT] ? frame_stb_active
           : pin_input_sample_r[gpx_pkg::PIN_T1];
    t0_nxt = cfg_r[gpx_pkg::TIMER0_TRIGGER_SELECT] ? frame_stb_active
           : pin_input_sample_r[gpx_pkg::PIN_T0];
    rx_nxt = cfg_r[gpx_pkg::SERIAL_RX_SOURCE_SELECT] ? 1'b0
           : pin_input_sample_r[gpx_pkg::PIN_RX];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_direction_r <= gpx_pkg::RST_PIN_DIRECTION;
      pin_output_latch_r <= gpx_pkg::RST_PIN_OUTPUT_LATCH;
      pin_input_sample_r <= gpx_pkg::RST_PIN_INPUT_SAMPLE;
      cfg_r <= gpx_pkg::RST_UTILITY_PIN_MUX_CONFIG;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wbyte_r <= '0;
      wlane_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= gpx_pkg::RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= gpx_pkg::RESP_OKAY;
      pin_out_r <= '0;
      pin_oe_r <= '0;
      rx_r <= 1'b0;
      t0_r <= 1'b0;
      t1_r <= 1'b0;
    end
    else
    begin
      pin_direction_r <= pin_direction_nxt;
      pin_output_latch_r <= pin_output_latch_nxt;
      pin_input_sample_r <= pin_in;
      cfg_r <= cfg_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      awaddr_r <= awaddr_nxt;
      wbyte_r <= wbyte_nxt;
      wlane_r <= wlane_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_direction_r;
      rx_r <= rx_nxt;
      t0_r <= t0_nxt;
      t1_r <= t1_nxt;
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;
  assign mcu_port3_bit0 = rx_r;
  assign mcu_port3_bit4 = t0_r;
  assign mcu_port3_bit5 = t1_r;

  // ==========================================================
  // checks
  sequence s_dir_write;
    do_wr && wlane_r && wsel == gpx_pkg::GPX_SEL_DIR;
  endsequence

  chk_dir_sets_oe: assert property (@(posedge aclk) disable iff (!aresetn)
    s_dir_write |-> ##2 pin_oe == $past(wbyte_r, 2))
    else $error("direction write not seen on output enable");

  chk_latch_drives_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 pin_out[7:5] == $past(pin_output_latch_r[7:5]))
    else $error("plain pins not driven from output latch");

  chk_input_read: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && arready_r && rsel == gpx_pkg::GPX_SEL_IN |=> rdata[7:0] == $past(pin_in, 2))
    else $error("input register read wrong sample");

  chk_pin4_mux: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 pin_out[4] == $past(cfg_r[4] ? frame_pulse : pin_output_latch_r[4]))
    else $error("pin 4 output mux wrong");

  chk_timer1_src: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_r[3] && frame_wr_stb |-> ##2 mcu_port3_bit5 [*8])
    else $error("timer 1 not fed by frame strobe");

  chk_timer0_src: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg_r[2] ##1 !cfg_r[2] |-> mcu_port3_bit4 == $past(pin_input_sample_r[2]))
    else $error("timer 0 not fed by pin 2");

  chk_pin1_mux: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_r[1] |=> pin_out[1] == $past(mcu_port3_bit1))
    else $error("pin 1 not carrying serial transmit");

  chk_rx_forced: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_r[0] |=> !mcu_port3_bit0)
    else $error("serial receive not forced low");

  chk_cfg_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && arready_r && rsel == gpx_pkg::GPX_SEL_CFG |=> rdata[31:5] == '0 && rvalid)
    else $error("config reserved bits not zero");
endmodule : gpx_port
`default_nettype wire

// ===== tb/gpx_pin_model.sv
// partner: pad levels seen by the port, with an external device on undriven pins
`timescale 1ns/10ps
`default_nettype none
module gpx_pin_model (
  // port side
  input wire logic [gpx_pkg::PIN_W-1:0] pin_out,
  input wire logic [gpx_pkg::PIN_W-1:0] pin_oe,
  // external device side
  input wire logic [gpx_pkg::PIN_W-1:0] ext_drv,
  output logic [gpx_pkg::PIN_W-1:0] pin_in
);
  // =====================================
  // pad resolution
  // driven pins loop back, so timer pins set as outputs reach the timers
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv);
endmodule : gpx_pin_model
`default_nettype wire

// ===== tb/tb.sv
// testbench: register bus, pin muxing and frame strobe checks for the pin port
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD %s exp %0h got %0h", nm, e, a); end end
module tb;
  // =====================================
  // signals
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, p3b1, fpulse, fstb, p3b0, p3b4, p3b5;
  logic [16:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] pin_in, pin_out, pin_oe, ext, v, w;
  logic [3:0] strb;
  logic [33:0] exp_q[$];
  logic [33:0] cur;
  integer seed = 32'hED7A;
  int n_errors = 0;
  int tests_run = 0;
  int n4, n5;
  localparam logic [16:0] DIR = gpx_pkg::IDX_PIN_DIRECTION;
  localparam logic [16:0] OUTL = gpx_pkg::IDX_PIN_OUTPUT_LATCH;
  localparam logic [16:0] INS = gpx_pkg::IDX_PIN_INPUT_SAMPLE;
  localparam logic [16:0] CFG = gpx_pkg::IDX_UTILITY_PIN_MUX_CONFIG;
  localparam logic [1:0] OK = gpx_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = gpx_pkg::RESP_SLVERR;
  gpx_port DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(strb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .mcu_port3_bit1(p3b1), .frame_pulse(fpulse), .frame_wr_stb(fstb),
    .mcu_port3_bit0(p3b0), .mcu_port3_bit4(p3b4), .mcu_port3_bit5(p3b5));
  gpx_pin_model PADS (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drv(ext), .pin_in(pin_in));
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // =====================================
  // read monitor: oldest note against each read answer
  always @(posedge aclk)
  begin
    if (rvalid && rready)
    begin
      if (exp_q.size() == 0)
      begin
        n_errors++;
        $display("BAD rvalid exp none got %0h", rdata);
      end
      else
      begin
        cur = exp_q.pop_front();
        `CHK("rresp", cur[33:32], rresp)
        `CHK("rdata", cur[31:0], rdata)
      end
    end
  end
  // =====================================
  // bus tasks
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic wr(input logic [16:0] idx, input logic [7:0] d, input logic [1:0] er);
    int i;
    @(posedge aclk);
    awaddr <= 17'(idx << 2);
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (i == 50)
    begin
      n_errors++;
      close_out();
    end
    `CHK("bresp", er, bresp)
  endtask : wr
  task automatic rd(input logic [16:0] idx, input logic [7:0] d, input logic [1:0] er);
    int i;
    @(posedge aclk);
    exp_q.push_back({er, 24'h000000, d});
    araddr <= 17'(idx << 2);
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (i == 50)
    begin
      n_errors++;
      close_out();
    end
  endtask : rd
  // =====================================
  // main sequence
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, p3b1, fpulse, fstb} <= 9'h000;
    {awaddr, araddr, wdata, ext} <= 74'h0;
    strb <= 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(DIR, 8'h00, OK);
    rd(OUTL, 8'h00, OK);
    rd(CFG, 8'h00, OK);
    $display("test reset done");
    for (int k = 0; k < 4; k++)
    begin
      v = 8'($random(seed));
      w = 8'($random(seed));
      wr(DIR, v, OK);
      wr(OUTL, w, OK);
      ext <= 8'($random(seed));
      repeat (3) @(posedge aclk);
      `CHK("pin_oe", v, pin_oe)
      `CHK("pin_out", w, pin_out)
      rd(DIR, v, OK);
      rd(OUTL, w, OK);
      rd(INS, (v & w) | (~v & ext), OK);
      wr(INS, 8'hA5, OK);
      rd(INS, (v & w) | (~v & ext), OK);
    end
    wr(17'h07F1C, 8'h55, ERR);
    rd(17'h07F1C, 8'h00, ERR);
    wr(CFG, 8'hFF, OK);
    rd(CFG, 8'h1F, OK);
    $display("test registers done");
    wr(DIR, 8'h12, OK);
    wr(OUTL, 8'h00, OK);
    ext <= 8'hFF;
    for (int i = 0; i < 4; i++)
    begin
      fpulse <= i[0];
      p3b1 <= i[1];
      repeat (4) @(posedge aclk);
      `CHK("pin4", i[0], pin_out[4])
      `CHK("pin1", i[1], pin_out[1])
      `CHK("rx_forced", 1'b0, p3b0)
    end
    wr(CFG, 8'h00, OK);
    for (int i = 0; i < 2; i++)
    begin
      ext <= {7'h7F, i[0]};
      repeat (4) @(posedge aclk);
      `CHK("rx_pin", i[0], p3b0)
      `CHK("pin4_latch", 1'b0, pin_out[4])
    end
    // low lane off: the write is answered but must leave direction alone
    strb <= 4'hE;
    wr(DIR, 8'hFF, OK);
    strb <= 4'hF;
    rd(DIR, 8'h12, OK);
    $display("test mux done");
    wr(DIR, 8'h0C, OK);
    for (int i = 0; i < 4; i++)
    begin
      wr(OUTL, {4'h0, i[1:0], 2'b00}, OK);
      repeat (4) @(posedge aclk);
      `CHK("timer0_pin", i[0], p3b4)
      `CHK("timer1_pin", i[1], p3b5)
    end
    // software-made low frame pulse on pin 3
    wr(OUTL, 8'h04, OK);
    repeat (2) @(posedge aclk);
    `CHK("low_pulse", 1'b0, pin_out[3])
    wr(OUTL, 8'h0C, OK);
    repeat (2) @(posedge aclk);
    `CHK("pulse_end", 1'b1, pin_out[3])
    wr(OUTL, 8'h00, OK);
    wr(CFG, 8'h0C, OK);
    @(posedge aclk);
    fstb <= 1'b1;
    @(posedge aclk);
    fstb <= 1'b0;
    n4 = 0;
    n5 = 0;
    repeat (260)
    begin
      @(posedge aclk);
      n4 += int'(p3b4);
      n5 += int'(p3b5);
    end
    `CHK("t0_stretch", 1'b1, n4 >= gpx_pkg::FRAME_STB_CYC && n4 < 210)
    `CHK("t1_stretch", 1'b1, n5 >= gpx_pkg::FRAME_STB_CYC && n5 < 210)
    `CHK("t0_end", 1'b0, p3b4)
    // missing frame: no strobe, so the timer 1 input on mcu_port3_bit5 stays quiet
    n5 = 0;
    repeat (260)
    begin
      @(posedge aclk);
      n5 += int'(p3b5);
    end
    `CHK("no_frame", 0, n5)
    $display("test frame strobe done");
    close_out();
  end
endmodule : tb
`default_nettype wire
